// ---- rtl/pol_protection_supervisor.sv ----
// Protection and warning supervisor with an APB register slave.
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "pps_consts.svh"
module pol_protection_supervisor #(
  parameter int          VW           = 16,
  parameter int unsigned RETRY_CYCLES = `PPS_RETRY_MS * `PPS_CLK_KHZ,
  parameter int unsigned CYC_PER_MS   = `PPS_CLK_KHZ
) (
  input  logic              clk_sys,
  input  logic              arst_n,
  input  logic              ce,
  input  logic [7:0]        paddr,
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [31:0]       pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  logic [VW-1:0]     vOut,
  input  logic [VW-1:0]     vSet,
  input  logic [VW-1:0]     vRamp,
  input  logic [VW-1:0]     vPrebias,
  input  logic [7:0]        iOut,
  input  logic signed [9:0] tempC,
  input  logic              runCmd,
  input  logic              rampingUp,
  input  logic              steadyState,
  input  logic              rampingDown,
  input  logic              pgPinIn,
  output logic              pgOut,
  output logic              pgOe,
  output logic              runAllow,
  output logic [1:0]        offStyle,
  output logic              hsOff,
  output logic              lsOn
);
  localparam int NF = 5;
  localparam int RW = $clog2(RETRY_CYCLES + 1);

  pps_ctl_if #(.VW(VW)) ctl ();

  logic [7:0]    cfgOne;
  logic [5:0]    cfgTwo;
  logic [7:0]    clsCfg;
  logic [10:0]   cfgThree;
  logic [NF-1:0] statusFault;
  logic          statusPg;
  logic          twFlag;
  logic [NF-1:0] faultActive;
  logic [NF-1:0] hit;
  logic [NF-1:0] gone;
  logic [NF-1:0] latchCfg;
  logic [NF-1:0] fastRel;
  wire  [NF-1:0] next_faultActive;
  wire  [NF-1:0] next_statusFault;
  wire  [NF-1:0] releaseNow;
  logic [RW-1:0] retryCnt;
  logic          retryTick;
  logic          pgSyncA;
  logic          pgSync;
  logic [1:0]    blankCnt;
  logic          trackArmed;
  logic          pgGood;
  logic          windowOk;
  logic          extLow;
  logic          dropPg;
  logic [VW:0]   vOutX;
  logic [VW:0]   diffAbs;
  logic          aboveBias;
  logic          ovHit;
  logic          uvHit;
  logic          ocHit;
  logic          otHit;
  logic          trHit;
  logic          setupPh;
  logic          accessPh;
  logic          wrEn;
  logic          statusWr;
  logic          mapped;
  logic [31:0]   readMux;
  pps_pkg::pps_style_t   next_style;
  pps_pkg::pps_pg_state_t pgState;
  pps_pkg::pps_pg_state_t next_pgState;

  pps_threshold_calc #(.VW(VW)) u_calc (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .ce      (ce),
    .cfgTwo  (cfgTwo),
    .clsCfg  (clsCfg),
    .vSet    (vSet),
    .tempC   (tempC),
    .lim     (ctl.calc)
  );

  pps_pg_delay #(.CYC_PER_MS(CYC_PER_MS)) u_pgdly (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .ce      (ce),
    .delayMs (cfgThree[7:0]),
    .tm      (ctl.timer)
  );

  // APB slave: no wait states, data and error prepared in the setup cycle.
  assign setupPh  = psel && !penable;
  assign accessPh = psel && penable && pready;
  assign wrEn     = accessPh && pwrite;
  assign statusWr = wrEn && paddr == `PPS_STATUS_OFS;

  always_comb begin
    mapped  = 1'b1;
    readMux = 32'h00000000;
    case (paddr)
      `PPS_CFG_ONE_OFS:   readMux = {24'h000000, cfgOne};
      `PPS_CFG_TWO_OFS:   readMux = {26'h0000000, cfgTwo};
      `PPS_CLS_OFS:       readMux = {24'h000000, clsCfg};
      `PPS_STATUS_OFS:    readMux = {25'h0000000, statusPg, !twFlag,
                                     statusFault};
      `PPS_CFG_THREE_OFS: readMux = {21'h000000, cfgThree};
      default:            mapped  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= setupPh;
      pslverr <= setupPh && !mapped;
      if (setupPh && !pwrite) begin
        prdata <= readMux;
      end
    end
  end

  // The threshold register only takes writes while the converter is off.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfgOne   <= `PPS_CFG_ONE_RST;
      cfgTwo   <= `PPS_CFG_TWO_RST;
      clsCfg   <= `PPS_CLS_RST;
      cfgThree <= `PPS_CFG_THREE_RST;
    end else if (ce && wrEn) begin
      case (paddr)
        `PPS_CFG_ONE_OFS: cfgOne <= pwdata[7:0];
        `PPS_CFG_TWO_OFS: begin
          if (!runAllow) begin
            cfgTwo <= pwdata[5:0];
          end
        end
        `PPS_CLS_OFS:       clsCfg   <= pwdata[7:0];
        `PPS_CFG_THREE_OFS: cfgThree <= pwdata[10:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pgSyncA <= 1'b1;
      pgSync  <= 1'b1;
    end else if (ce) begin
      pgSyncA <= pgPinIn;
      pgSync  <= pgSyncA;
    end
  end

  // Protection detectors.
  assign vOutX     = {1'b0, vOut};
  assign aboveBias = vOut > vPrebias;
  assign diffAbs   = (vOut > vRamp) ? vOutX - {1'b0, vRamp}
                                    : {1'b0, vRamp} - vOutX;
  assign ocHit = aboveBias && {1'b0, iOut} >= ctl.ocLimit;
  assign uvHit = steadyState && vOutX < ctl.uvLimit && !ocHit;
  assign otHit = tempC > `PPS_OT_SET_C;
  assign trHit = cfgOne[`PPS_TRACK_EN_BIT] && trackArmed && rampingUp
                 && diffAbs > (VW+1)'(`PPS_TRACK_MV);
  assign ovHit = aboveBias && vOutX > ctl.ovLimit;
  assign hit      = {trHit, otHit, ocHit, uvHit, ovHit};
  assign latchCfg = cfgOne[5:1];
  assign fastRel  = 5'h08;
  always_comb begin
    gone = ~hit;
    gone[`PPS_IDX_OT] = tempC < `PPS_TW_SET_C;
  end

  // Fault latches and their active-low status bits; a new event beats a clear.
  for (genvar i = 0; i < NF; i++) begin : g_fault
    assign releaseNow[i] = faultActive[i] && !hit[i] && gone[i]
        && (!latchCfg[i] || statusFault[i] || !runCmd)
        && (retryTick || (fastRel[i] && !latchCfg[i]));
    assign next_faultActive[i] = hit[i] ? 1'b1 :
                                 (releaseNow[i] ? 1'b0 : faultActive[i]);
    assign next_statusFault[i] = hit[i] ? 1'b0 :
        ((statusWr && pwdata[i]) ? 1'b1 : statusFault[i]);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      faultActive <= '0;
      statusFault <= `PPS_STATUS_RST;
    end else if (ce) begin
      faultActive <= next_faultActive;
      statusFault <= next_statusFault;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      retryCnt  <= '0;
      retryTick <= 1'b0;
    end else if (ce) begin
      retryTick <= 1'b0;
      if (faultActive == '0) begin
        retryCnt <= '0;
      end else if (retryCnt == RW'(RETRY_CYCLES - 1)) begin
        retryCnt  <= '0;
        retryTick <= 1'b1;
      end else begin
        retryCnt <= retryCnt + {{(RW-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      twFlag <= 1'b0;
    end else if (ce) begin
      if (tempC > `PPS_TW_SET_C) begin
        twFlag <= 1'b1;
      end else if (tempC < `PPS_TW_CLR_C) begin
        twFlag <= 1'b0;
      end
    end
  end

  // Turn-off style from latched faults and fresh hits, most severe first.
  always_comb begin
    logic [NF-1:0] f;
    f = faultActive | hit;
    if (f[`PPS_IDX_OV]) begin
      next_style = pps_pkg::STYLE_EMERG;
    end else if (f[`PPS_IDX_OC] || f[`PPS_IDX_TR]
                 || (f[`PPS_IDX_UV] && cfgThree[`PPS_UV_CRIT_BIT])
                 || (f[`PPS_IDX_OT] && cfgThree[`PPS_OT_CRIT_BIT])) begin
      next_style = pps_pkg::STYLE_CRIT;
    end else if (f != '0) begin
      next_style = pps_pkg::STYLE_SEQ;
    end else begin
      next_style = pps_pkg::STYLE_NONE;
    end
  end

  // Only faults gate the run permission; the warning flags never do.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      runAllow <= 1'b0;
      offStyle <= 2'b00;
      hsOff    <= 1'b1;
      lsOn     <= 1'b0;
    end else if (ce) begin
      runAllow <= runCmd && next_style == pps_pkg::STYLE_NONE;
      offStyle <= next_style;
      hsOff    <= !runCmd || next_style == pps_pkg::STYLE_CRIT
                  || next_style == pps_pkg::STYLE_EMERG;
      lsOn     <= next_style == pps_pkg::STYLE_EMERG;
    end
  end

  // Power good sequencing.
  assign dropPg = (faultActive != '0) || (cfgThree[`PPS_PG_AT_CMD_BIT]
                  ? !runCmd : rampingDown);
  assign windowOk = vOutX >= ctl.pgLow && vOutX <= ctl.pgHigh;
  assign extLow   = !pgSync && !pgOe && blankCnt == 2'b00;
  assign pgGood   = pgState == pps_pkg::PG_ACTIVE && windowOk && !extLow;
  assign ctl.pgStart = pgState == pps_pkg::PG_DELAY;

  always_comb begin
    next_pgState = pgState;
    case (pgState)
      pps_pkg::PG_IDLE: begin
        if (runAllow && steadyState && !dropPg) begin
          next_pgState = pps_pkg::PG_DELAY;
        end
      end
      pps_pkg::PG_DELAY: begin
        if (dropPg) begin
          next_pgState = pps_pkg::PG_IDLE;
        end else if (ctl.pgDone) begin
          next_pgState = pps_pkg::PG_ACTIVE;
        end
      end
      pps_pkg::PG_ACTIVE: begin
        if (dropPg) begin
          next_pgState = pps_pkg::PG_IDLE;
        end
      end
      default: next_pgState = pps_pkg::PG_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pgState  <= pps_pkg::PG_IDLE;
      pgOe     <= 1'b1;
      pgOut    <= 1'b0;
      statusPg <= 1'b0;
      blankCnt <= 2'b11;
    end else if (ce) begin
      pgState  <= next_pgState;
      // An external low is only reported; driving the pin would mask it.
      pgOe     <= !(pgState == pps_pkg::PG_ACTIVE && windowOk);
      pgOut    <= 1'b0;
      statusPg <= pgGood;
      // The pin needs the synchroniser depth to read high after release.
      blankCnt <= pgOe ? 2'b11 : ((blankCnt != 2'b00) ? blankCnt - 2'b01
                                                       : 2'b00);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      trackArmed <= 1'b1;
    end else if (ce) begin
      if (!runCmd) begin
        trackArmed <= 1'b1;
      end else if (pgGood) begin
        trackArmed <= 1'b0;
      end
    end
  end

  tw_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && tempC > `PPS_TW_SET_C |=> twFlag && readMux[5] == 1'b0
      || paddr != `PPS_STATUS_OFS)
    else $error("temperature warning not raised");
  tw_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && twFlag && tempC >= `PPS_TW_CLR_C |=> twFlag)
    else $error("temperature warning dropped inside hysteresis");
  warn_no_stop_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    ce && runCmd && faultActive == '0 && hit == '0 |=> runAllow)
    else $error("converter stopped without a fault");
  oc_fast_off_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    ce && ocHit |=> hsOff && !runAllow && !statusFault[`PPS_IDX_OC]
      && faultActive[`PPS_IDX_OC])
    else $error("overcurrent did not open switches");
  ov_emerg_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && ovHit |=> hsOff && lsOn && offStyle == 2'b11)
    else $error("overvoltage did not force emergency style");
  uv_seq_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && uvHit && !cfgThree[`PPS_UV_CRIT_BIT] && faultActive == '0
      && hit == 5'h02 |=> offStyle == 2'b01 && !hsOff == runCmd)
    else $error("undervoltage not sequenced");
  track_fault_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    ce && trHit |=> !statusFault[`PPS_IDX_TR] && hsOff && !lsOn == !ovHit
      || $past(ovHit))
    else $error("tracking error not handled");
  pg_low_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && !windowOk |=> pgOe && !statusPg)
    else $error("power good not pulled low outside window");
  status_set_wins_a: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    ce && otHit && statusWr && pwdata[`PPS_IDX_OT] |=>
      !statusFault[`PPS_IDX_OT])
    else $error("status clear beat a new overtemperature event");
endmodule : pol_protection_supervisor

// ---- rtl/pps_consts.svh ----
// Offsets, field positions, reset values and timing for the supervisor.
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH
`define PPS_CFG_ONE_OFS   8'h00
`define PPS_CFG_TWO_OFS   8'h04
`define PPS_CLS_OFS       8'h08
`define PPS_STATUS_OFS    8'h0C
`define PPS_CFG_THREE_OFS 8'h10
`define PPS_CFG_ONE_RST   8'h43
`define PPS_CFG_TWO_RST   6'h08
`define PPS_CLS_RST       8'h1B
`define PPS_CFG_THREE_RST 11'h000
`define PPS_STATUS_RST    5'h1F
`define PPS_IDX_OV 0
`define PPS_IDX_UV 1
`define PPS_IDX_OC 2
`define PPS_IDX_OT 3
`define PPS_IDX_TR 4
`define PPS_TRACK_EN_BIT  7
`define PPS_PG_AT_CMD_BIT 8
`define PPS_UV_CRIT_BIT   9
`define PPS_OT_CRIT_BIT   10
`define PPS_TCE_BIT       4
`define PPS_PGL_BIT       4
`define PPS_PGH_BIT       5
`define PPS_TW_SET_C      10'sh078
`define PPS_TW_CLR_C      10'sh075
`define PPS_OT_SET_C      10'sh082
`define PPS_ROOM_C        10'sh019
`define PPS_TRACK_MV      16'h00FA
`define PPS_OV_FLOOR_MV   16'h01F4
`define PPS_OV_MARGIN_MV  16'h00FA
`define PPS_PCT_DIV       8'h64
`define PPS_OC_BASE_PCT   8'h25
`define PPS_OC_STEP_PCT   8'h0A
`define PPS_UV_BASE_PCT   8'h4B
`define PPS_RETRY_MS      32'h00000082
`define PPS_PG_DELAY_MAX_MS 8'h96
`define PPS_CLK_KHZ       32'h000186A0
`endif

// ---- rtl/pps_ctl_if.sv ----
// Limits and power good timer handshake between the supervisor modules.
`timescale 1ns/1ps
interface pps_ctl_if #(parameter int VW = 16);
  logic [VW:0] ovLimit;
  logic [VW:0] uvLimit;
  logic [VW:0] pgHigh;
  logic [VW:0] pgLow;
  logic [8:0]  ocLimit;
  logic        pgStart;
  logic        pgDone;
  modport calc (output ovLimit, uvLimit, pgHigh, pgLow, ocLimit);
  modport timer (input pgStart, output pgDone);
  modport core (input ovLimit, uvLimit, pgHigh, pgLow, ocLimit, pgDone,
                output pgStart);
endinterface : pps_ctl_if

// ---- rtl/pps_pg_delay.sv ----
// Millisecond delay timer before power good is released.
`timescale 1ns/1ps
`include "pps_consts.svh"
module pps_pg_delay #(
  parameter int unsigned CYC_PER_MS = `PPS_CLK_KHZ
) (
  input  logic       clk_sys,
  input  logic       arst_n,
  input  logic       ce,
  input  logic [7:0] delayMs,
  pps_ctl_if.timer   tm
);
  localparam int CW = $clog2(CYC_PER_MS + 1);
  logic [CW-1:0] subCnt;
  logic [7:0]    msCnt;
  logic [7:0]    limitMs;

  assign limitMs = (delayMs > `PPS_PG_DELAY_MAX_MS) ? `PPS_PG_DELAY_MAX_MS
                                                    : delayMs;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      subCnt    <= '0;
      msCnt     <= '0;
      tm.pgDone <= 1'b0;
    end else if (ce) begin
      if (!tm.pgStart) begin
        subCnt    <= '0;
        msCnt     <= '0;
        tm.pgDone <= 1'b0;
      end else if (!tm.pgDone) begin
        if (msCnt >= limitMs) begin
          tm.pgDone <= 1'b1;
        end else if (subCnt == CW'(CYC_PER_MS - 1)) begin
          subCnt <= '0;
          msCnt  <= msCnt + 8'h01;
        end else begin
          subCnt <= subCnt + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  pg_delay_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && tm.pgStart && !tm.pgDone && msCnt < limitMs |=> !tm.pgDone)
    else $error("power good released before its delay");
endmodule : pps_pg_delay

// ---- rtl/pps_pkg.sv ----
// Types shared by the supervisor modules.
package pps_pkg;
  typedef enum logic [1:0] {
    STYLE_NONE  = 2'b00,
    STYLE_SEQ   = 2'b01,
    STYLE_CRIT  = 2'b10,
    STYLE_EMERG = 2'b11
  } pps_style_t;
  typedef enum logic [1:0] {
    PG_IDLE   = 2'b00,
    PG_DELAY  = 2'b01,
    PG_ACTIVE = 2'b10
  } pps_pg_state_t;
endpackage : pps_pkg

// ---- rtl/pps_threshold_calc.sv ----
// Registered protection limits, the voltage ones scaled from the output setpoint.
`timescale 1ns/1ps
`include "pps_consts.svh"
module pps_threshold_calc #(
  parameter int VW = 16
) (
  input  logic              clk_sys,
  input  logic              arst_n,
  input  logic              ce,
  input  logic [5:0]        cfgTwo,
  input  logic [7:0]        clsCfg,
  input  logic [VW-1:0]     vSet,
  input  logic signed [9:0] tempC,
  pps_ctl_if.calc           lim
);
  function automatic logic [VW:0] scalePct(input logic [VW-1:0] v,
                                           input logic [7:0] p);
    logic [VW+7:0] prod;
    prod = {8'h00, v} * {{VW{1'b0}}, p};
    return (VW+1)'(prod / (VW+8)'(`PPS_PCT_DIV));
  endfunction : scalePct

  logic [7:0]        ovPct;
  logic [7:0]        uvPct;
  logic [VW:0]       ovRaw;
  logic [VW:0]       ovMin;
  logic [VW:0]       next_ov;
  logic [8:0]        next_oc;
  logic signed [9:0] tempDelta;

  always_comb begin
    case (cfgTwo[3:2])
      2'b00:   ovPct = 8'h6E;
      2'b01:   ovPct = 8'h73;
      2'b10:   ovPct = 8'h78;
      default: ovPct = 8'h82;
    endcase
    uvPct = `PPS_UV_BASE_PCT + {4'h0, cfgTwo[1:0], 2'b00} + {6'h00, cfgTwo[1:0]};
    // The overvoltage limit is the largest of ratio, floor and margin.
    ovRaw = scalePct(vSet, ovPct);
    ovMin = {1'b0, vSet} + (VW+1)'(`PPS_OV_MARGIN_MV);
    if ((VW+1)'(`PPS_OV_FLOOR_MV) > ovMin) begin
      ovMin = (VW+1)'(`PPS_OV_FLOOR_MV);
    end
    next_ov = (ovRaw > ovMin) ? ovRaw : ovMin;
    tempDelta = tempC - `PPS_ROOM_C;
    next_oc = {1'b0, `PPS_OC_BASE_PCT} + 9'(clsCfg[3:0]) * 9'(`PPS_OC_STEP_PCT);
    if (clsCfg[`PPS_TCE_BIT] && tempC > `PPS_ROOM_C) begin
      next_oc = next_oc + {1'b0, tempDelta[9:2]};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lim.ovLimit <= '0;
      lim.uvLimit <= '0;
      lim.pgHigh  <= '0;
      lim.pgLow   <= '0;
      lim.ocLimit <= '0;
    end else if (ce) begin
      lim.ovLimit <= next_ov;
      lim.uvLimit <= scalePct(vSet, uvPct);
      lim.pgHigh  <= scalePct(vSet, cfgTwo[`PPS_PGH_BIT] ? 8'h69 : 8'h6E);
      lim.pgLow   <= scalePct(vSet, cfgTwo[`PPS_PGL_BIT] ? 8'h5F : 8'h5A);
      lim.ocLimit <= next_oc;
    end
  end

  ov_margin_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce |=> (lim.ovLimit >= {1'b0, $past(vSet)} + (VW+1)'(`PPS_OV_MARGIN_MV)))
    else $error("overvoltage limit below setpoint margin");
endmodule : pps_threshold_calc

// ---- verif/pps_pg_wire.sv ----
// Power good wire with its pull-up and an external pull-down source.
`timescale 1ns/1ps
module pps_pg_wire (
  input  logic pgOe,
  input  logic extLow,
  output logic pgLevel
);
  // The wire reads high only when nobody pulls it low.
  assign pgLevel = !(pgOe || extLow);
endmodule : pps_pg_wire

// ---- verif/testbench.sv ----
// Self-checking bench for the protection supervisor.
`timescale 1ns/1ps
module testbench;
  logic        clk_sys, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, iOut;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] vOut, vSet, vRamp, vPrebias;
  logic signed [9:0] tempC;
  logic        runCmd, rampingUp, steadyState, rampingDown, extLow;
  logic        pgOut, pgOe, pgLevel, runAllow, hsOff, lsOn, er;
  logic [1:0]  offStyle;
  int          err_total, total_checks, cyc;
  int          seed = 32'hf276;

  pol_protection_supervisor #(.RETRY_CYCLES(200), .CYC_PER_MS(10))
    pol_protection_supervisor_inst (.ce(1'b1), .pgPinIn(pgLevel), .*);
  pps_pg_wire pps_pg_wire_inst (.pgOe(pgOe), .extLow(extLow),
                                .pgLevel(pgLevel));

  always #5 clk_sys = ~clk_sys;

  function automatic logic [7:0] oc_lim(input logic [3:0] code);
    return 8'(37 + 10 * code);
  endfunction : oc_lim

  function automatic logic [15:0] ov_lim(input int v, input int pct);
    int p;
    p = v * pct / 100;
    if (p < 500) p = 500;
    if (p < v + 250) p = v + 250;
    return 16'(p);
  endfunction : ov_lim

  task automatic final_report;
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %0h got %0h", nm, e, s);
    end
  endtask : chk

  task automatic st(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : st

  task automatic ap(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1 && n++ < 50);
    if (pready !== 1'b1) err_total++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : ap

  // Reads the status word and compares one of its bits.
  task automatic rs(input int b, input logic e);
    ap(1'b0, 8'h0C, 32'h0);
    chk("status", rd[b], e);
  endtask : rs

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    clk_sys = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; vOut = 0; vSet = 16'h03E8; vRamp = 0;
    vPrebias = 0; iOut = 0; tempC = 10'sh019; runCmd = 0;
    rampingUp = 0; steadyState = 0; rampingDown = 0; extLow = 0;
    st(16);
    arst_n <= 1'b1;
    st(2);
    ap(1'b0, 8'h00, 0); chk("cfg1", rd, 32'h43);
    ap(1'b0, 8'h0C, 0); chk("status", rd, 32'h3F);
    ap(1'b0, 8'h14, 0); chk("slverr", er, 1'b1);
    ap(1'b1, 8'h00, 32'hC3);
    runCmd <= 1; rampingUp <= 1; vRamp <= 500; vOut <= 750; st(4);
    chk("trk250", runAllow, 1'b1);
    vOut <= 751; st(3);
    chk("trk251", {offStyle, hsOff, lsOn}, 4'hA);
    rs(4, 1'b0);
    rampingUp <= 0; vOut <= 1000; ap(1'b1, 8'h0C, 32'h1F); st(250);
    steadyState <= 1; st(30);
    chk("pgGood", pgOe, 1'b0);
    rs(6, 1'b1);
    ap(1'b1, 8'h04, 32'h30); ap(1'b0, 8'h04, 0);
    chk("cfg2", rd, 32'h08);
    vOut <= 899; st(3); chk("pgLow", pgOe, 1'b1);
    vOut <= 1000; st(4); chk("pgBack", pgOe, 1'b0);
    extLow <= 1; st(6); rs(6, 1'b0);
    extLow <= 0; tempC <= 121; st(3); rs(5, 1'b0);
    chk("warnRun", runAllow, 1'b1);
    tempC <= 118; st(3); rs(5, 1'b0);
    tempC <= 116; st(3); rs(5, 1'b1);
    tempC <= 10'sh019;
    repeat (20) begin
      iOut <= 8'($unsigned($random(seed)) % oc_lim(4'hB));
      vOut <= 16'(950 + $unsigned($random(seed)) % 100);
      st(3); chk("rnd", runAllow, 1'b1);
    end
    vOut <= 1000; iOut <= oc_lim(4'hB); st(3);
    chk("oc", {offStyle, hsOff, lsOn}, 4'hA);
    rs(2, 1'b0);
    iOut <= 0; ap(1'b1, 8'h0C, 32'h1F); st(250);
    chk("retry", runAllow, 1'b1);
    vOut <= ov_lim(1000, 120); st(3); chk("ovEq", runAllow, 1'b1);
    vOut <= ov_lim(1000, 120) + 1; st(3);
    chk("ov", {offStyle, hsOff, lsOn}, 4'hF);
    rs(0, 1'b0);
    vOut <= 1000; ap(1'b1, 8'h0C, 32'h1F); st(250);
    tempC <= 131; st(3); chk("ot", {runAllow, offStyle}, 3'b001);
    rs(3, 1'b0);
    tempC <= 119; st(4); chk("otBack", runAllow, 1'b1);
    st(30); chk("pgRe", pgOe, 1'b0);
    rampingDown <= 1; st(3); chk("pgDown", pgOe, 1'b1);
    chk("pgOut", pgOut, 1'b0);
    rampingDown <= 0; vOut <= 700; st(3);
    chk("uv", {runAllow, offStyle}, 3'b001);
    rs(1, 1'b0);
    final_report();
  end
endmodule : testbench
